// file: ccl_cfg.svh
// Purpose: Constants for the chopper current limiter
// Assumes: 200 MHz system clock, thresholds coded in 50 mA steps
// Notes:   Offsets are byte addresses on the plain register port
`ifndef CCL_CFG_SVH
`define CCL_CFG_SVH

`define CCL_CLK_MHZ      200
`define CCL_BLANK_NS     11500
`define CCL_TOFF_NS      20500
`define CCL_BLANK_CYC    ((`CCL_BLANK_NS * `CCL_CLK_MHZ + 999) / 1000)
`define CCL_TOFF_CYC     ((`CCL_TOFF_NS * `CCL_CLK_MHZ + 999) / 1000)

`define CCL_OFS_CTRL     8'h00
`define CCL_OFS_STATUS   8'h04

`define CCL_CTRL_COMB    0
`define CCL_CTRL_USEL_A  1
`define CCL_CTRL_HSEL_A  2
`define CCL_CTRL_USEL_B  3
`define CCL_CTRL_HSEL_B  4
`define CCL_CTRL_RST     5'h00

`define CCL_STAT_OPEN_A  2
`define CCL_STAT_OPEN_B  3

`define CCL_I_6P5        9'h082
`define CCL_I_4P6        9'h05C
`define CCL_I_13         9'h104
`define CCL_I_9P2        9'h0B8
`define CCL_I_2P5        9'h032
`define CCL_H_0P25       9'h005
`define CCL_H_0P5        9'h00A
`define CCL_H_1P0        9'h014

`endif

// file: ccl_pkg.sv
// Purpose: Types for the chopper current limiter
// Assumes: Nothing beyond the constants header
// Notes:   All four state codes are legal
package ccl_pkg;
   typedef enum logic [1:0]
   {
      CCL_RUN   = 2'b00,
      CCL_BLANK = 2'b01,
      CCL_TOFF  = 2'b10,
      CCL_HOLD  = 2'b11
   } ccl_state_t;
endpackage : ccl_pkg

// file: ccl_top.sv
// Purpose: Chopper current limiter and bridge drive arbitration, two channels
// Assumes: Comparator and fault inputs are asynchronous levels from analog
// Notes:   Thresholds are coded in 50 mA steps for the threshold DACs
// Operation
// - Fault indicator returns high by itself when over-temperature ends.
// - Compare low-side current to upper and lower thresholds, slow decay while limiting.
// - Reset thresholds are 6.5 A upper and 0.25 A hysteresis per channel.
// - Dual mode: per channel 6.5 or 4.6 A with 0.25 or 0.5 A hysteresis.
// - Combined mode: 13 or 9.2 A total with 0.5 or 1.0 A hysteresis.
// - Over-threshold starts blanking; limit asserts if still over after 11.5 us.
// - Limit forces short brake on both low sides and starts minimum off time.
// - After 20.5 us off time with current below lower threshold, drive resumes.
// - Drive input is ignored while minimum off time runs.
// - Drive input low during blanking brakes at once.
// - Current above lower threshold at off-time end keeps brake and limit.
// - Current reaching lower threshold ends limit; drive resumes if input high.
// - Outside limiting, drive input low brakes, high drives in commanded direction.
// - Thermal warning drops upper threshold to 2.5 A, lower follows.
// - Open load drives fault indicator low and sets a status flag.
// - Current monitor stays on when disabled, off in sleep.
// - Fault indicator low while over-temperature, high once it clears.
// - Sleep input low turns all major circuits off.
`timescale 1ns/1ps
`include "ccl_cfg.svh"

module ccl_top
   import ccl_pkg::*;
#(
   parameter int unsigned TOFF_CYC = `CCL_TOFF_CYC
)
(
   input  wire logic        SYS_CLK,
   input  wire logic        SRST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   input  wire logic        DRIVE_PWM_INPUT_A,
   input  wire logic        DRIVE_PWM_INPUT_B,
   input  wire logic        DRIVE_DIR_A,
   input  wire logic        DRIVE_DIR_B,
   input  wire logic        DRIVE_ENABLE_LO,
   input  wire logic        SLEEP_REQUEST_N,
   input  wire logic        OVER_TEMP,
   input  wire logic        THERMAL_WARN,
   input  wire logic        OPEN_LOAD_A,
   input  wire logic        OPEN_LOAD_B,
   input  wire logic        CMP_HI_A,
   input  wire logic        CMP_LO_A,
   input  wire logic        CMP_HI_B,
   input  wire logic        CMP_LO_B,
   output logic             BRIDGE_OUT_A1_HI,
   output logic             BRIDGE_OUT_A1_LO,
   output logic             BRIDGE_OUT_A2_HI,
   output logic             BRIDGE_OUT_A2_LO,
   output logic             BRIDGE_OUT_B1_HI,
   output logic             BRIDGE_OUT_B1_LO,
   output logic             BRIDGE_OUT_B2_HI,
   output logic             BRIDGE_OUT_B2_LO,
   output logic             LIMIT_A,
   output logic             LIMIT_B,
   output logic      [8:0]  THR_HI_A,
   output logic      [8:0]  THR_LO_A,
   output logic      [8:0]  THR_HI_B,
   output logic      [8:0]  THR_LO_B,
   output logic             FAULT_INDICATOR_N,
   output logic             CURRENT_MONITOR_EN
);

   localparam logic [12:0] BLANK_LAST = 13'(`CCL_BLANK_CYC - 1);
   localparam logic [12:0] TOFF_LAST  = 13'(TOFF_CYC - 1);

   // Upper and lower threshold codes for one channel
   function automatic logic [17:0] ccl_thr(input logic comb, input logic usel,
                                           input logic hsel, input logic warn);
      logic [8:0] hi;
      logic [8:0] hy;
      hi = comb ? (usel ? `CCL_I_9P2 : `CCL_I_13) : (usel ? `CCL_I_4P6 : `CCL_I_6P5);
      hy = comb ? (hsel ? `CCL_H_1P0 : `CCL_H_0P5) : (hsel ? `CCL_H_0P5 : `CCL_H_0P25);
      if (warn)
      begin
         hi = `CCL_I_2P5;
      end
      return {hi, 9'(hi - hy)};
   endfunction : ccl_thr

   // Pin synchronisers
   logic [13:0] meta;
   logic [13:0] sync;
   logic [13:0] next_meta;
   logic [1:0]  pwm_s;
   logic [1:0]  dir_s;
   logic [1:0]  open_s;
   logic [1:0]  cmp_hi;
   logic [1:0]  cmp_lo;
   logic        en_lo_s;
   logic        awake;
   logic        ot_s;
   logic        warn_s;

   always_comb
   begin
      next_meta = {CMP_LO_B, CMP_HI_B, CMP_LO_A, CMP_HI_A, OPEN_LOAD_B, OPEN_LOAD_A, THERMAL_WARN,
                   OVER_TEMP, SLEEP_REQUEST_N, DRIVE_ENABLE_LO, DRIVE_DIR_B, DRIVE_DIR_A,
                   DRIVE_PWM_INPUT_B, DRIVE_PWM_INPUT_A};
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         meta <= 14'h0000;
         sync <= 14'h0000;
      end
      else
      begin
         meta <= next_meta;
         sync <= meta;
      end
   end

   assign pwm_s   = sync[1:0];
   assign dir_s   = sync[3:2];
   assign en_lo_s = sync[4];
   assign awake   = sync[5];
   assign ot_s    = sync[6];
   assign warn_s  = sync[7];
   assign open_s  = sync[9:8];
   assign cmp_hi  = {sync[12], sync[10]};
   assign cmp_lo  = {sync[13], sync[11]};

   // Register file
   logic [4:0]  ctrl;
   logic [1:0]  open_flag;
   logic [31:0] rdata;
   logic [4:0]  next_ctrl;
   logic [1:0]  next_open_flag;
   logic [31:0] next_rdata;
   ccl_state_t  st [2];
   logic        comb_mode;

   assign comb_mode = ctrl[`CCL_CTRL_COMB];

   always_comb
   begin
      next_ctrl = ctrl;
      next_open_flag = open_flag;
      next_rdata = 32'h0000_0000;
      if (WR && ADDR == `CCL_OFS_CTRL)
      begin
         next_ctrl = WDATA[4:0];
      end
      if (WR && ADDR == `CCL_OFS_STATUS)
      begin
         next_open_flag = open_flag & ~WDATA[`CCL_STAT_OPEN_B:`CCL_STAT_OPEN_A];
      end
      next_open_flag = next_open_flag | open_s;
      if (RD && ADDR == `CCL_OFS_CTRL)
      begin
         next_rdata = {27'h000_0000, ctrl};
      end
      else if (RD && ADDR == `CCL_OFS_STATUS)
      begin
         next_rdata = {22'h00_0000, st[1], st[0], warn_s, ot_s, open_flag, st[1][1], st[0][1]};
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         ctrl      <= `CCL_CTRL_RST;
         open_flag <= 2'b00;
         rdata     <= 32'h0000_0000;
      end
      else
      begin
         ctrl      <= next_ctrl;
         open_flag <= next_open_flag;
         rdata     <= next_rdata;
      end
   end

   assign RDATA = rdata;

   // Per-channel limit machines
   logic [12:0] cnt [2];
   ccl_state_t  next_st [2];
   logic [12:0] next_cnt [2];
   logic [1:0]  hi_sel;
   logic [1:0]  lo_sel;

   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         hi_sel[i] = comb_mode ? cmp_hi[0] : cmp_hi[i];
         lo_sel[i] = comb_mode ? cmp_lo[0] : cmp_lo[i];
         next_st[i] = st[i];
         next_cnt[i] = cnt[i];
         if (!awake)
         begin
            next_st[i] = CCL_RUN;
            next_cnt[i] = 13'h0000;
         end
         else
         begin
            unique case (st[i])
               CCL_RUN:
               begin
                  if (hi_sel[i])
                  begin
                     next_st[i] = CCL_BLANK;
                     next_cnt[i] = 13'h0000;
                  end
               end
               CCL_BLANK:
               begin
                  next_cnt[i] = 13'(cnt[i] + 13'h0001);
                  if (cnt[i] == BLANK_LAST)
                  begin
                     next_cnt[i] = 13'h0000;
                     next_st[i] = hi_sel[i] ? CCL_TOFF : CCL_RUN;
                  end
               end
               CCL_TOFF:
               begin
                  next_cnt[i] = 13'(cnt[i] + 13'h0001);
                  if (cnt[i] == TOFF_LAST)
                  begin
                     next_cnt[i] = 13'h0000;
                     next_st[i] = lo_sel[i] ? CCL_HOLD : CCL_RUN;
                  end
               end
               CCL_HOLD:
               begin
                  if (!lo_sel[i])
                  begin
                     next_st[i] = CCL_RUN;
                  end
               end
            endcase
         end
         if (comb_mode && i == 1)
         begin
            next_st[1] = next_st[0];
            next_cnt[1] = next_cnt[0];
         end
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (SRST)
         begin
            st[i]  <= CCL_RUN;
            cnt[i] <= 13'h0000;
         end
         else
         begin
            st[i]  <= next_st[i];
            cnt[i] <= next_cnt[i];
         end
      end
   end

   assign LIMIT_A = st[0][1];
   assign LIMIT_B = st[1][1];

   // Bridge drive, thresholds, fault and monitor outputs
   logic [7:0]  drv;
   logic [7:0]  next_drv;
   logic [35:0] thr;
   logic [35:0] next_thr;
   logic        fault_n;
   logic        mon_en;
   logic        next_fault_n;
   logic        drive_en;
   logic [1:0]  brake;

   assign drive_en = awake && !en_lo_s;

   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         brake[i] = st[i][1] || !pwm_s[i];
         next_drv[4*i+0] = drive_en && !brake[i] && dir_s[i];
         next_drv[4*i+1] = drive_en && (brake[i] || !dir_s[i]);
         next_drv[4*i+2] = drive_en && !brake[i] && !dir_s[i];
         next_drv[4*i+3] = drive_en && (brake[i] || dir_s[i]);
      end
      next_thr = {ccl_thr(comb_mode, ctrl[comb_mode ? `CCL_CTRL_USEL_A : `CCL_CTRL_USEL_B],
                          ctrl[comb_mode ? `CCL_CTRL_HSEL_A : `CCL_CTRL_HSEL_B], warn_s),
                  ccl_thr(comb_mode, ctrl[`CCL_CTRL_USEL_A], ctrl[`CCL_CTRL_HSEL_A], warn_s)};
      next_fault_n = !(ot_s || (|open_s));
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         drv     <= 8'h00;
         thr     <= {`CCL_I_6P5, 9'(`CCL_I_6P5 - `CCL_H_0P25), `CCL_I_6P5, 9'(`CCL_I_6P5 - `CCL_H_0P25)};
         fault_n <= 1'b1;
         mon_en  <= 1'b0;
      end
      else
      begin
         drv     <= next_drv;
         thr     <= next_thr;
         fault_n <= next_fault_n;
         mon_en  <= awake;
      end
   end

   assign {BRIDGE_OUT_A2_LO, BRIDGE_OUT_A2_HI, BRIDGE_OUT_A1_LO, BRIDGE_OUT_A1_HI} = drv[3:0];
   assign {BRIDGE_OUT_B2_LO, BRIDGE_OUT_B2_HI, BRIDGE_OUT_B1_LO, BRIDGE_OUT_B1_HI} = drv[7:4];
   assign {THR_HI_B, THR_LO_B, THR_HI_A, THR_LO_A} = thr;
   assign FAULT_INDICATOR_N  = fault_n;
   assign CURRENT_MONITOR_EN = mon_en;

   // Checks
   logic [12:0] lim_len;

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST || !st[0][1])
      begin
         lim_len <= 13'h0000;
      end
      else if (lim_len != 13'h1FFF)
      begin
         lim_len <= 13'(lim_len + 13'h0001);
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   blank_limit_a: assert property (st[0] == CCL_BLANK && cnt[0] == BLANK_LAST && hi_sel[0] && awake
                                   |=> LIMIT_A && st[0] == CCL_TOFF)
      else $error("limit not raised after blanking");
   limit_cause_a: assert property ($rose(LIMIT_A) |-> $past(st[0]) == CCL_BLANK)
      else $error("limit raised without blanking");
   brake_out_a: assert property (LIMIT_A && drive_en |=> BRIDGE_OUT_A1_LO && BRIDGE_OUT_A2_LO
                                 && !BRIDGE_OUT_A1_HI && !BRIDGE_OUT_A2_HI)
      else $error("limit without short brake");
   toff_len_a: assert property ($fell(LIMIT_A) && $past(awake) |-> $past(lim_len) >= TOFF_LAST)
      else $error("off time cut short");
   pwm_ignored_a: assert property (st[0] == CCL_TOFF && drive_en && pwm_s[0]
                                   |=> !BRIDGE_OUT_A1_HI && !BRIDGE_OUT_A2_HI)
      else $error("drive during off time");
   pwm_brake_a: assert property (drive_en && !pwm_s[0] |=> BRIDGE_OUT_A1_LO && BRIDGE_OUT_A2_LO)
      else $error("drive input low without brake");
   hold_limit_a: assert property (st[0] == CCL_TOFF && cnt[0] == TOFF_LAST && lo_sel[0] && awake
                                  |=> st[0] == CCL_HOLD && LIMIT_A)
      else $error("brake released above lower threshold");
   resume_a: assert property (!LIMIT_A && drive_en && pwm_s[0] && dir_s[0]
                              |=> BRIDGE_OUT_A1_HI && BRIDGE_OUT_A2_LO && !BRIDGE_OUT_A1_LO)
      else $error("forward drive not restored");
   thr_reset_a: assert property (ctrl == 5'h00 && !warn_s |=> THR_HI_A == 9'h082 && THR_LO_A == 9'h07D)
      else $error("default threshold wrong");
   thr_warn_a: assert property (warn_s |=> THR_HI_A == 9'h032 && THR_LO_A < 9'h032)
      else $error("thermal warning threshold wrong");
   fault_ot_a: assert property (ot_s |=> !FAULT_INDICATOR_N)
      else $error("fault indicator high in over-temperature");
   fault_free_a: assert property (!ot_s && open_s == 2'b00 |=> FAULT_INDICATOR_N)
      else $error("fault indicator stuck low");
   open_flag_a: assert property (open_s[0] |=> open_flag[0] && !FAULT_INDICATOR_N)
      else $error("open load not flagged");
   comb_sync_a: assert property (comb_mode && $past(comb_mode) |-> st[0] == st[1])
      else $error("combined channels diverged");
   monitor_a: assert property (CURRENT_MONITOR_EN == $past(awake))
      else $error("monitor enable wrong");

   limit_seen_c: cover property ($rose(LIMIT_A));
   hold_seen_c: cover property (st[0] == CCL_HOLD);
   warn_seen_c: cover property (warn_s && LIMIT_B);

endmodule : ccl_top

// file: ccl_host_chan.sv
// Purpose: Host drive model for one channel of the current limiter
// Assumes: Requests come from the bench; outputs change just after the clock edge
// Notes:   A direction change always passes through a short brake first
`timescale 1ns/1ps
module ccl_host_chan
#(
   parameter int unsigned BRK_CYC = 4
)
(
   input  wire logic clk,
   input  wire logic pwm_req,
   input  wire logic dir_req,
   output logic      pwm,
   output logic      dir
);
   int unsigned gap = 0;
   // One process owns both outputs so each has a single driver
   initial
   begin
      pwm = 1'b0;
      dir = 1'b1;
      forever
      begin
         @(posedge clk);
         if (dir_req !== dir)
         begin
            pwm <= 1'b0;
            if (gap >= BRK_CYC)
            begin
               dir <= dir_req;
               gap <= 0;
            end
            else
            begin
               gap <= gap + 1;
            end
         end
         else
         begin
            pwm <= pwm_req;
         end
      end
   end
endmodule : ccl_host_chan

// file: ccl_top_tb_top.sv
// Purpose: Self-checking bench for the chopper current limiter
// Assumes: Short off time of 20 cycles, blanking of 2300 cycles
// Notes:   Expected codes are in 50 mA steps
`timescale 1ns/1ps
module ccl_top_tb_top;
   localparam int unsigned TOFF = 20;
   logic sys_clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [7:0]  addr  = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic pwm_req_a = 1'b0, dir_req_a = 1'b1, pwm_req_b = 1'b0, dir_req_b = 1'b1;
   logic pwm_a, dir_a, pwm_b, dir_b;
   logic dis = 1'b0, sleep_n = 1'b1, otemp = 1'b0, warn = 1'b0, open_a = 1'b0, open_b = 1'b0;
   logic chi_a = 1'b0, clo_a = 1'b0, chi_b = 1'b0, clo_b = 1'b0;
   logic a1h, a1l, a2h, a2l, b1h, b1l, b2h, b2l, lim_a, lim_b, fault_n, mon_en;
   logic [8:0]  thi_a, tlo_a, thi_b, tlo_b;
   int          n_errors = 0;
   int          n_checks = 0;
   wire  [3:0]  br_a = {a1h, a1l, a2h, a2l};
   wire  [3:0]  br_b = {b1h, b1l, b2h, b2l};
   wire  [35:0] thr  = {thi_a, tlo_a, thi_b, tlo_b};

   ccl_host_chan host_a (.clk(sys_clk), .pwm_req(pwm_req_a), .dir_req(dir_req_a), .pwm(pwm_a), .dir(dir_a));
   ccl_host_chan host_b (.clk(sys_clk), .pwm_req(pwm_req_b), .dir_req(dir_req_b), .pwm(pwm_b), .dir(dir_b));

   ccl_top #(.TOFF_CYC(TOFF)) dut_u (
      .SYS_CLK(sys_clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .DRIVE_PWM_INPUT_A(pwm_a), .DRIVE_PWM_INPUT_B(pwm_b), .DRIVE_DIR_A(dir_a), .DRIVE_DIR_B(dir_b),
      .DRIVE_ENABLE_LO(dis), .SLEEP_REQUEST_N(sleep_n), .OVER_TEMP(otemp), .THERMAL_WARN(warn),
      .OPEN_LOAD_A(open_a), .OPEN_LOAD_B(open_b), .CMP_HI_A(chi_a), .CMP_LO_A(clo_a),
      .CMP_HI_B(chi_b), .CMP_LO_B(clo_b),
      .BRIDGE_OUT_A1_HI(a1h), .BRIDGE_OUT_A1_LO(a1l), .BRIDGE_OUT_A2_HI(a2h), .BRIDGE_OUT_A2_LO(a2l),
      .BRIDGE_OUT_B1_HI(b1h), .BRIDGE_OUT_B1_LO(b1l), .BRIDGE_OUT_B2_HI(b2h), .BRIDGE_OUT_B2_LO(b2l),
      .LIMIT_A(lim_a), .LIMIT_B(lim_b), .THR_HI_A(thi_a), .THR_LO_A(tlo_a), .THR_HI_B(thi_b),
      .THR_LO_B(tlo_b), .FAULT_INDICATOR_N(fault_n), .CURRENT_MONITOR_EN(mon_en));

   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic t_reset;
      logic [31:0] d;
      chk(thr, {9'h082, 9'h07D, 9'h082, 9'h07D});
      chk({lim_a, lim_b, fault_n}, 3'b001);
      rd_reg(8'h40, d);
      chk(d, 32'h0000_0000);
   endtask : t_reset

   task automatic t_thresholds;
      logic [8:0] ha, la, hb, lb;
      for (int c = 0; c < 16; c++)
      begin
         wr_reg(8'h00, 32'(c) << 1);
         cyc(3);
         ha = c[0] ? 9'h05C : 9'h082;
         la = ha - (c[1] ? 9'h00A : 9'h005);
         hb = c[2] ? 9'h05C : 9'h082;
         lb = hb - (c[3] ? 9'h00A : 9'h005);
         chk(thr, {ha, la, hb, lb});
      end
      for (int c = 0; c < 4; c++)
      begin
         wr_reg(8'h00, (32'(c) << 1) | 32'h0000_0001);
         cyc(3);
         ha = c[0] ? 9'h0B8 : 9'h104;
         la = ha - (c[1] ? 9'h014 : 9'h00A);
         chk(thr, {ha, la, ha, la});
      end
      wr_reg(8'h00, 32'h0000_0004);
      warn <= 1'b1;
      cyc(6);
      chk(thr, {9'h032, 9'h028, 9'h032, 9'h02D});
      warn <= 1'b0;
      cyc(6);
      chk(thr, {9'h082, 9'h078, 9'h082, 9'h07D});
      wr_reg(8'h00, 32'h0000_0000);
   endtask : t_thresholds

   task automatic t_drive;
      pwm_req_a <= 1'b1;
      pwm_req_b <= 1'b1;
      cyc(8);
      chk({br_a, br_b}, 8'h99);
      pwm_req_a <= 1'b0;
      cyc(8);
      chk(br_a, 4'b0101);
      dir_req_a <= 1'b0;
      pwm_req_a <= 1'b1;
      cyc(16);
      chk(br_a, 4'b0110);
      dir_req_a <= 1'b1;
      cyc(16);
      chk(br_a, 4'b1001);
   endtask : t_drive

   task automatic t_chop;
      chi_a <= 1'b1;
      clo_a <= 1'b1;
      cyc(2302);
      chk(lim_a, 1'b0);
      cyc(1);
      chk(lim_a, 1'b1);
      chi_a <= 1'b0;
      cyc(2);
      chk(br_a, 4'b0101);
      pwm_req_a <= 1'b0;
      cyc(TOFF + 10);
      pwm_req_a <= 1'b1;
      cyc(8);
      chk({lim_a, br_a}, 5'b10101);
      clo_a <= 1'b0;
      cyc(6);
      chk({lim_a, br_a}, 5'b01001);
   endtask : t_chop

   task automatic t_blank_pwm;
      chi_a <= 1'b1;
      chi_b <= 1'b1;
      cyc(100);
      pwm_req_a <= 1'b0;
      cyc(6);
      chk({lim_a, br_a}, 5'b00101);
      chi_a <= 1'b0;
      cyc(2197);
      chk({lim_a, lim_b}, 2'b01);
      chi_b <= 1'b0;
      cyc(103);
      pwm_req_a <= 1'b1;
      cyc(8);
      chk({lim_a, lim_b, br_a, br_b}, 10'h099);
   endtask : t_blank_pwm

   task automatic t_comb;
      wr_reg(8'h00, 32'h0000_0001);
      chi_a <= 1'b1;
      clo_a <= 1'b1;
      cyc(2302);
      chk({lim_a, lim_b}, 2'b00);
      cyc(1);
      chk({lim_a, lim_b}, 2'b11);
      chi_a <= 1'b0;
      clo_a <= 1'b0;
      cyc(2);
      chk({lim_a, lim_b, br_a, br_b}, 10'h355);
      cyc(TOFF + 8);
      chk({lim_a, lim_b, br_a, br_b}, 10'h099);
      wr_reg(8'h00, 32'h0000_0000);
   endtask : t_comb

   task automatic t_fault;
      logic [31:0] d;
      otemp <= 1'b1;
      cyc(5);
      chk(fault_n, 1'b0);
      otemp <= 1'b0;
      cyc(5);
      chk(fault_n, 1'b1);
      open_a <= 1'b1;
      open_b <= 1'b1;
      cyc(5);
      chk(fault_n, 1'b0);
      rd_reg(8'h04, d);
      chk(d[3:2], 2'b11);
      open_a <= 1'b0;
      open_b <= 1'b0;
      cyc(5);
      chk(fault_n, 1'b1);
      wr_reg(8'h04, 32'h0000_0004);
      rd_reg(8'h04, d);
      chk(d[3:2], 2'b10);
      wr_reg(8'h04, 32'h0000_0008);
      rd_reg(8'h04, d);
      chk(d[3:2], 2'b00);
   endtask : t_fault

   task automatic t_sleep;
      dis <= 1'b1;
      cyc(6);
      chk({mon_en, br_a, br_b}, 9'h100);
      sleep_n <= 1'b0;
      cyc(6);
      chk({mon_en, br_a, br_b}, 9'h000);
      sleep_n <= 1'b1;
      dis     <= 1'b0;
      cyc(8);
      chk({mon_en, br_a, br_b}, 9'h199);
   endtask : t_sleep

   task automatic end_of_test;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   initial
   begin
      #200_000;
      n_errors++;
      end_of_test;
   end

   initial
   begin
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      cyc(4);
      t_reset;
      t_thresholds;
      t_drive;
      t_chop;
      t_blank_pwm;
      t_comb;
      t_fault;
      t_sleep;
      end_of_test;
   end
endmodule : ccl_top_tb_top
